// ==== verilog/jla_pkg.sv ====
// Shared constants and carrier types for the link alignment block
package jla_pkg;
  localparam int BLK_PER_MB = 32;
  localparam logic [4:0] LAST_BLK = 5'h1f;
  localparam logic [4:0] EOMB_FIRST = 5'h1b;
  localparam logic [4:0] EOEMB_POS = 5'h16;
  localparam logic [1:0] SH_ONE = 2'h1;
  localparam logic [1:0] SH_ZERO = 2'h2;
  localparam logic [7:0] K28_7 = 8'hfc;
  localparam logic [7:0] K28_3 = 8'h7c;
  localparam logic [7:0] SCR_FRAME_OCT = 8'hfc;
  localparam logic [7:0] SCR_MF_OCT = 8'h7c;
  localparam logic [1:0] SHM_CRC12 = 2'h0;
  localparam logic [1:0] SHM_FEC = 2'h2;
  localparam int CRC_W = 12;
  localparam int FEC_W = 26;
  localparam logic [11:0] CRC12_GEN = 12'h987;
  // Generator printed without its constant term; taps below x^12
  localparam logic [25:0] CRC12_TAPS = {14'h0000, CRC12_GEN[10:0], 1'b1};
  localparam logic [25:0] FEC_TAPS = 26'h0220211;
  localparam logic [57:0] SCR_SEED = 58'h0;
  localparam int SCR_TAP_A = 38;
  localparam int SCR_TAP_B = 57;
  localparam int FIFO_DEPTH = 4;

  typedef struct packed {
    logic [1:0] sh;
    logic [63:0] payload;
  } jla_block_t;

  typedef struct packed {
    logic k;
    logic [7:0] octet;
  } jla_char_t;

  typedef struct packed {
    logic [57:0] st;
    logic [63:0] dat;
  } jla_scr_t;
endpackage

// ==== verilog/jla_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module jla_fifo import jla_pkg::*; #(
  parameter int WIDTH = 64,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Fill side
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire logic [WIDTH-1:0] IN_DATA,
  // Drain side
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [WIDTH-1:0] OUT_DATA
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } jla_fifo_st_t;

  jla_fifo_st_t s, n;
  logic wr, rd;

  assign IN_READY = s.cnt != CW'(DEPTH);
  assign OUT_VALID = s.cnt != '0;
  assign OUT_DATA = s.mem[s.rp];
  assign wr = IN_VALID && IN_READY;
  assign rd = OUT_VALID && OUT_READY;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    n = s;
    if (wr) begin
      n.mem[s.wp] = IN_DATA;
      n.wp = bump(s.wp);
    end
    if (rd) begin
      n.rp = bump(s.rp);
    end
    if (wr && !rd) begin
      n.cnt = s.cnt + 1'b1;
    end else if (rd && !wr) begin
      n.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  fifo_bound_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    s.cnt <= CW'(DEPTH)) else $error("fifo count above depth");
endmodule // jla_fifo

// ==== verilog/jla_link_align.sv ====
// Transmit link-layer alignment: 8B/10B character substitution, 64B/66B
// block framing with sync header stream and parity
`timescale 1ns/100ps
// What this block does
// - Unscrambled, repeated frame-final octet goes out as /F/ K28.7.
// - Unscrambled, repeated multiframe-final octet goes out as /A/ K28.3.
// - Scrambled, frame-final octet 0xFC goes out as /F/.
// - Scrambled, multiframe-final octet 0x7C goes out as /A/.
// - 64B/66B packs eight octets per block, scrambles, adds 2-bit header.
// - 32 blocks form a multiblock; E multiblocks an extended multiblock.
// - Local extended-multiblock clock, reset by SYSREF, period 32*E blocks.
// - Sync header bits are always complementary, 01 or 10.
// - Header 01 sends one, 10 sends zero; 32 bits form the stream.
// - Stream ends in 00001; in CRC mode nowhere else.
// - Stream bit 22 is one only in the last multiblock of each group.
// - Stream carries CRC-12 or FEC parity; no CRC-3 or command channel.
// - CRC-12 over a multiblock's scrambled data goes in the next one.
// - Mode select 0 chooses CRC-12.
// - In CRC-12 mode the seven command bits are zero.
// - Parity polynomial 0x987, cleared per multiblock, headers excluded.
// - Mode select 2 chooses FEC with 26-bit parity.
// - 64B/66B payloads are always scrambled, before header insertion.
module jla_link_align import jla_pkg::*; (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Configuration
  input wire logic MODE_64B66B,
  input wire logic SCRAMBLE_EN,
  input wire logic [1:0] SYNC_HEADER_MODE_SELECT,
  input wire logic [7:0] FRAME_OCTETS_M1,
  input wire logic [7:0] MF_FRAMES_M1,
  input wire logic [7:0] EMB_MB_M1,
  input wire logic DATA_PHASE,
  // Timing reference pin
  input wire logic SYSREF,
  // Transport frames in, eight octets a word, first octet in top byte
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire logic [63:0] IN_DATA,
  // 8B/10B character stream
  output logic CHAR_VALID,
  output jla_char_t CHAR,
  // 64B/66B block stream
  output logic BLOCK_VALID,
  output jla_block_t BLOCK,
  output logic LEMC_EDGE
);
  typedef struct packed {
    logic sr1;
    logic sr2;
    logic sr_prev;
    logic [4:0] blk;
    logic [7:0] mb;
    logic [2:0] oct;
    logic have;
    logic [63:0] word;
    logic [7:0] fo;
    logic [7:0] fr;
    logic [7:0] prev_last;
    logic [25:0] acc;
    logic [25:0] par;
    logic [57:0] scr;
    logic ch_v;
    jla_char_t ch;
    logic bk_v;
    jla_block_t bk;
    logic [4:0] bk_idx;
    logic bk_emb_last;
    logic bk_fec;
    logic lemc;
  } jla_state_t;

  jla_state_t s, n;
  logic f_valid, f_pop, sysref_edge, eof, eomf, fec;
  logic [63:0] f_data;
  logic [7:0] oc;
  logic [31:0] stream;
  logic [25:0] acc_nx;
  jla_scr_t sc;

  jla_fifo #(
    .WIDTH(64),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .IN_VALID(IN_VALID),
    .IN_READY(IN_READY),
    .IN_DATA(IN_DATA),
    .OUT_VALID(f_valid),
    .OUT_READY(f_pop),
    .OUT_DATA(f_data)
  );

  // Self-synchronous 1 + x^39 + x^58, first bit is the MSB
  function automatic jla_scr_t scramble(input logic [57:0] st,
                                        input logic [63:0] d);
    jla_scr_t r;
    logic b;
    r.st = st;
    r.dat = '0;
    for (int i = 63; i >= 0; i--) begin
      b = d[i] ^ r.st[SCR_TAP_A] ^ r.st[SCR_TAP_B];
      r.dat[i] = b;
      r.st = {r.st[56:0], b};
    end
    return r;
  endfunction

  // Serial parity over 64 bits; top selects 12- or 26-bit register
  function automatic logic [25:0] par_step(input logic [25:0] st,
                                           input logic [63:0] d,
                                           input logic [25:0] taps,
                                           input int top);
    logic [25:0] r;
    logic [25:0] mask;
    logic fb;
    r = st;
    for (int j = 0; j < 26; j++) begin
      mask[j] = (j <= top);
    end
    for (int i = 63; i >= 0; i--) begin
      fb = d[i] ^ r[top];
      r = {r[24:0], 1'b0};
      if (fb) begin
        r = r ^ taps;
      end
      r = r & mask;
    end
    return r;
  endfunction

  // Stream bit 0 is carried by block 0 of the multiblock
  function automatic logic [31:0] sh_stream(input logic [25:0] p,
                                            input logic fec_mode,
                                            input logic emb_last);
    logic [31:0] w;
    if (fec_mode) begin
      w[21:0] = {p[4], p[5], p[6], p[7], p[8], p[9], p[10], p[11],
                 p[12], p[13], p[14], p[15], p[16], p[17], p[18], p[19],
                 p[20], p[21], p[22], p[23], p[24], p[25]};
      w[26:23] = {p[0], p[1], p[2], p[3]};
    end else begin
      w[21:0] = {1'b1, 1'b0, 1'b1, 3'h0, 1'b1, p[0], p[1], p[2], 1'b1,
                 p[3], p[4], p[5], 1'b1, p[6], p[7], p[8], 1'b1, p[9],
                 p[10], p[11]};
      w[26:23] = {3'h0, 1'b1};
    end
    w[22] = emb_last;
    w[31:27] = 5'h10;
    return w;
  endfunction

  assign sysref_edge = s.sr2 && !s.sr_prev;
  assign oc = s.word[8 * (3'h7 - s.oct) +: 8];
  assign eof = s.fo == FRAME_OCTETS_M1;
  assign eomf = eof && s.fr == MF_FRAMES_M1;
  // other codes fall back to CRC-12, never command channel
  assign fec = SYNC_HEADER_MODE_SELECT == SHM_FEC;
  // always scrambled; idle cycles send a scrambled zero block
  assign sc = scramble(s.scr, f_valid ? f_data : 64'h0);
  assign stream = sh_stream(s.par, fec, s.mb == EMB_MB_M1);
  assign acc_nx = par_step(s.acc, sc.dat, fec ? FEC_TAPS : CRC12_TAPS,
                           fec ? FEC_W - 1 : CRC_W - 1);

  always_comb begin
    n = s;
    f_pop = 1'b0;
    n.sr1 = SYSREF;
    n.sr2 = s.sr1;
    n.sr_prev = s.sr2;
    n.ch_v = 1'b0;
    n.bk_v = 1'b0;
    n.lemc = 1'b0;
    if (MODE_64B66B) begin
      // one 64-bit block per cycle, then header
      f_pop = f_valid;
      n.scr = sc.st;
      n.bk_v = 1'b1;
      n.bk.payload = sc.dat;
      // one as 01, zero as 10
      n.bk.sh = stream[s.blk] ? SH_ONE : SH_ZERO;
      n.bk_idx = s.blk;
      n.bk_emb_last = s.mb == EMB_MB_M1;
      n.bk_fec = fec;
      n.lemc = s.blk == 5'h0 && s.mb == 8'h0;
      if (s.blk == LAST_BLK) begin
        n.par = acc_nx;
        n.acc = '0;
        n.blk = 5'h0;
        n.mb = (s.mb == EMB_MB_M1) ? 8'h0 : s.mb + 8'h1;
      end else begin
        n.acc = acc_nx;
        n.blk = s.blk + 5'h1;
      end
    end else begin
      if (s.have) begin
        n.ch_v = 1'b1;
        n.ch.k = 1'b0;
        n.ch.octet = oc;
        if (DATA_PHASE && eof) begin
          if (SCRAMBLE_EN) begin
            if (eomf && oc == SCR_MF_OCT) begin
              n.ch.k = 1'b1;
              n.ch.octet = K28_3;
            end else if (oc == SCR_FRAME_OCT) begin
              n.ch.k = 1'b1;
              n.ch.octet = K28_7;
            end
          end else if (oc == s.prev_last) begin
            n.ch.k = 1'b1;
            n.ch.octet = eomf ? K28_3 : K28_7;
          end
        end
        if (eof) begin
          n.prev_last = oc;
          n.fo = 8'h0;
          n.fr = (s.fr == MF_FRAMES_M1) ? 8'h0 : s.fr + 8'h1;
        end else begin
          n.fo = s.fo + 8'h1;
        end
        n.oct = s.oct + 3'h1;
      end
      // Reload on the last octet so the stream has no bubble
      if (!s.have || s.oct == 3'h7) begin
        f_pop = f_valid;
        n.have = f_valid;
        n.oct = 3'h0;
        if (f_valid) begin
          n.word = f_data;
        end
      end
    end
    // a periodic SYSREF lands on the same phase each time
    if (sysref_edge) begin
      n.blk = 5'h0;
      n.mb = 8'h0;
      n.acc = '0;
      n.fo = 8'h0;
      n.fr = 8'h0;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s <= '0;
      s.scr <= SCR_SEED;
    end else begin
      s <= n;
    end
  end

  assign CHAR_VALID = s.ch_v;
  assign CHAR = s.ch;
  assign BLOCK_VALID = s.bk_v;
  assign BLOCK = s.bk;
  assign LEMC_EDGE = s.lemc;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  sequence s_sysref_in_64;
    sysref_edge && MODE_64B66B;
  endsequence

  sequence s_lemc_out;
    LEMC_EDGE && BLOCK_VALID;
  endsequence

  sh_complement_a: assert property (
    BLOCK_VALID |-> (BLOCK.sh == SH_ONE || BLOCK.sh == SH_ZERO))
    else $error("sync header not complementary");

  eomb_tail_a: assert property (
    BLOCK_VALID && s.bk_idx >= EOMB_FIRST |->
      BLOCK.sh == ((s.bk_idx == LAST_BLK) ? SH_ONE : SH_ZERO))
    else $error("end-of-multiblock marker wrong");

  eoemb_bit_a: assert property (
    BLOCK_VALID && s.bk_idx == EOEMB_POS |->
      (BLOCK.sh == SH_ONE) == s.bk_emb_last)
    else $error("extended group end bit wrong");

  cmd_zero_a: assert property (
    BLOCK_VALID && !s.bk_fec && (s.bk_idx inside {5'h10, 5'h11, 5'h12,
      5'h14, 5'h18, 5'h19, 5'h1a}) |-> BLOCK.sh == SH_ZERO)
    else $error("command bit not zero");

  lemc_phase_a: assert property (
    s_sysref_in_64 ##1 MODE_64B66B[*2] |-> s_lemc_out and s.bk_idx == 5'h0)
    else $error("group start not two cycles after SYSREF edge");

  repeat_f_a: assert property (
    !MODE_64B66B && s.have && DATA_PHASE && !SCRAMBLE_EN && eof && !eomf
      && oc == s.prev_last |=> CHAR_VALID && CHAR.k && CHAR.octet == K28_7)
    else $error("repeated octet not sent as F");

  repeat_a_a: assert property (
    !MODE_64B66B && s.have && DATA_PHASE && !SCRAMBLE_EN && eomf
      && oc == s.prev_last |=> CHAR.k && CHAR.octet == K28_3)
    else $error("repeated multiframe octet not sent as A");

  scr_f_a: assert property (
    !MODE_64B66B && s.have && DATA_PHASE && SCRAMBLE_EN && eof && !eomf
      && oc == SCR_FRAME_OCT |=> CHAR.k && CHAR.octet == K28_7)
    else $error("scrambled FC not sent as F");

  scr_a_a: assert property (
    !MODE_64B66B && s.have && DATA_PHASE && SCRAMBLE_EN && eomf
      && oc == SCR_MF_OCT |=> CHAR.k && CHAR.octet == K28_3)
    else $error("scrambled 7C not sent as A");

  ilas_clean_a: assert property (
    !MODE_64B66B && s.have && !DATA_PHASE |=> CHAR_VALID && !CHAR.k)
    else $error("substitution outside data phase");

  parity_clear_a: assert property (
    MODE_64B66B && s.blk == LAST_BLK |=> s.acc == '0)
    else $error("parity register not cleared per multiblock");
endmodule // jla_link_align

// ==== verif/jla_rx_model.sv ====
// Receiver-side model: header checks, stream gathering, parity, descrambling
`timescale 1ns/100ps
module jla_rx_model import jla_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Block stream from the transmitter
  input wire logic block_valid,
  input jla_block_t block,
  input wire logic lemc_edge,
  // Per multiblock results, and a running count of bad headers since reset
  output logic mb_done,
  output logic mb_first,
  output logic [31:0] sh_word,
  output logic [11:0] crc_mb,
  output logic [25:0] fec_mb,
  output int bad_sh,
  // Descrambled payload of each block
  output logic desc_valid,
  output logic [63:0] desc_data
);
  logic [4:0] idx;
  logic [31:0] w;
  logic [11:0] c;
  logic [25:0] f;
  logic [57:0] st;
  logic [63:0] d;
  logic first, bi, fc, ff;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {mb_done, mb_first, desc_valid} <= 3'h0;
      bad_sh <= 0;
      idx = 5'h1f;
      st = '0;
    end else begin
      mb_done <= 1'b0;
      desc_valid <= 1'b0;
      if (block_valid) begin
        if (block.sh == 2'h0 || block.sh == 2'h3) bad_sh <= bad_sh + 1;
        idx = lemc_edge ? 5'h00 : idx + 5'h01;
        if (idx == 5'h00) begin
          first = lemc_edge;
          c = '0;
          f = '0;
        end
        w[idx] = (block.sh == SH_ONE);
        for (int b = 63; b >= 0; b--) begin
          bi = block.payload[b];
          fc = bi ^ c[11];
          ff = bi ^ f[25];
          // parity recomputed over the received multiblock
          c = {c[10:0], 1'b0} ^ (fc ? CRC12_TAPS[11:0] : 12'h000);
          f = {f[24:0], 1'b0} ^ (ff ? FEC_TAPS : 26'h0);
          // Self-synchronous, so it locks after one block whatever the seed
          d[b] = bi ^ st[SCR_TAP_A] ^ st[SCR_TAP_B];
          st = {st[56:0], bi};
        end
        desc_valid <= 1'b1;
        desc_data <= d;
        if (idx == 5'h1f) begin
          mb_done <= 1'b1;
          mb_first <= first;
          sh_word <= w;
          crc_mb <= c;
          fec_mb <= f;
        end
      end
    end
  end
endmodule // jla_rx_model

// ==== verif/tb_jla_link_align.sv ====
// Self-checking bench for the link alignment block
`timescale 1ns/100ps
module tb_jla_link_align import jla_pkg::*;;
  localparam int F = 2;
  localparam int K = 2;
  localparam int E = 2;
  logic CLOCK, RST_N, MODE_64B66B, SCRAMBLE_EN, DATA_PHASE, SYSREF;
  logic [1:0] SYNC_HEADER_MODE_SELECT;
  logic IN_VALID, IN_READY, CHAR_VALID, BLOCK_VALID, LEMC_EDGE;
  logic [63:0] IN_DATA, desc_data, w;
  jla_char_t CHAR;
  jla_block_t BLOCK;
  logic mb_done, mb_first, desc_valid;
  logic [31:0] sh_word, msk;
  logic [11:0] crc_mb, crc_last;
  logic [25:0] fec_mb, fec_last;
  logic [7:0] prev;
  int bad_sh, n_mismatch, total_checks, seed, pos, mbi, nmb, k;
  bit chk64, synced, have_prev, saw_full;
  logic [8:0] cq[$];
  logic [7:0] oq[$];
  logic [7:0] rx_prev, rx_oct;
  logic [31:0] xw;
  int rpos, rx_mis;
  bit rx_fe, rx_me;
  logic [63:0] wq[$];

  jla_link_align i_jla_link_align (.CLOCK(CLOCK), .RST_N(RST_N),
    .MODE_64B66B(MODE_64B66B), .SCRAMBLE_EN(SCRAMBLE_EN),
    .SYNC_HEADER_MODE_SELECT(SYNC_HEADER_MODE_SELECT),
    .FRAME_OCTETS_M1(8'(F - 1)), .MF_FRAMES_M1(8'(K - 1)),
    .EMB_MB_M1(8'(E - 1)),
    .DATA_PHASE(DATA_PHASE), .SYSREF(SYSREF), .IN_VALID(IN_VALID),
    .IN_READY(IN_READY), .IN_DATA(IN_DATA), .CHAR_VALID(CHAR_VALID),
    .CHAR(CHAR), .BLOCK_VALID(BLOCK_VALID), .BLOCK(BLOCK),
    .LEMC_EDGE(LEMC_EDGE));

  jla_rx_model i_jla_rx_model (.clock(CLOCK), .rst_n(RST_N),
    .block_valid(BLOCK_VALID), .block(BLOCK), .lemc_edge(LEMC_EDGE),
    .mb_done(mb_done), .mb_first(mb_first), .sh_word(sh_word),
    .crc_mb(crc_mb), .fec_mb(fec_mb), .bad_sh(bad_sh),
    .desc_valid(desc_valid), .desc_data(desc_data));

  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic bail();
    n_mismatch++;
    tally_and_finish();
  endtask

  task automatic cmp_char(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t char got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_val(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic push(input logic [63:0] v);
    int n;
    n = 0;
    @(negedge CLOCK);
    IN_VALID = 1'b1;
    IN_DATA = v;
    while (IN_READY !== 1'b1) begin
      if (++n > 400) bail();
      @(negedge CLOCK);
    end
    @(posedge CLOCK);
  endtask

  // one-shot pulses only, never a free-running SYSREF
  task automatic sysref();
    @(negedge CLOCK);
    SYSREF = 1'b1;
    repeat (3) @(negedge CLOCK);
    SYSREF = 1'b0;
    repeat (6) @(negedge CLOCK);
  endtask

  // Builds one word of frames and the characters it must become
  task automatic word8();
    logic [7:0] o;
    bit fe, me;
    int s;
    for (int j = 0; j < 8; j++) begin
      s = $random(seed) & 3;
      o = 8'($random(seed));
      fe = (pos % F) == F - 1;
      me = fe && (pos / F) == K - 1;
      if (fe) o = s == 0 ? prev : s == 1 ? 8'hfc : s == 2 ? 8'h7c : o;
      w[63-8*j -: 8] = o;
      oq.push_back(o);
      // no substitution outside the data phase
      if (!fe || !DATA_PHASE) cq.push_back({1'b0, o});
      else if (!SCRAMBLE_EN)
        cq.push_back(o == prev ? {1'b1, me ? K28_3 : K28_7} : {1'b0, o});
      else if (me && o == SCR_MF_OCT) cq.push_back({1'b1, K28_3});
      else cq.push_back(o == SCR_FRAME_OCT ? {1'b1, K28_7} : {1'b0, o});
      if (fe) prev = o;
      pos = (pos + 1) % (F * K);
    end
    push(w);
  endtask

  function automatic logic [31:0] exp_sw(input bit fec, input bit eoemb);
    logic [31:0] s;
    s = fec ? 32'h8000_0000 : 32'h80a8_8888;
    s[22] = eoemb;
    for (int i = 0; i < 22 && fec; i++) s[i] = fec_last[25-i];
    for (int i = 0; i < 4 && fec; i++) s[23+i] = fec_last[3-i];
    for (int i = 0; i < 12 && !fec; i++) s[i+i/3] = crc_last[11-i];
    return s;
  endfunction

  always @(negedge CLOCK) if (IN_VALID && IN_READY === 1'b0) saw_full = 1;

  always @(posedge CLOCK) begin
    if (CHAR_VALID === 1'b1) begin
      cmp_char(CHAR, cq.size() ? cq.pop_front() : 'x);
      rx_fe = (rpos % F) == F - 1;
      rx_me = rx_fe && (rpos / F) == K - 1;
      rx_oct = CHAR.octet;
      if (CHAR.k === 1'b1) begin
        // alignment characters only at frame ends
        if (!rx_fe || (CHAR.octet == K28_3 && !rx_me)) rx_mis++;
        // restore the octet the character stands for
        rx_oct = SCRAMBLE_EN ? (CHAR.octet == K28_7 ? SCR_FRAME_OCT :
          SCR_MF_OCT) : rx_prev;
      end
      if (rx_fe) rx_prev = rx_oct;
      rpos = (rpos + 1) % (F * K);
      cmp_val(rx_oct, oq.size() ? oq.pop_front() : 'x);
    end
    if (chk64 && desc_valid === 1'b1 && desc_data !== 64'h0)
      cmp_val(desc_data, wq.size() ? wq.pop_front() : 'x);
    if (chk64 && mb_done === 1'b1) begin
      if (mb_first === 1'b1) begin
        if (synced) cmp_val(mbi, E - 1);
        synced = 1;
        mbi = 0;
      end else mbi++;
      if (synced) begin
        msk = have_prev ? '1 : SYNC_HEADER_MODE_SELECT == SHM_FEC ?
          32'hf840_0000 : 32'hffff_8888;
        xw = exp_sw(SYNC_HEADER_MODE_SELECT == SHM_FEC, mbi == E - 1);
        cmp_val(sh_word & msk, xw & msk);
        have_prev = 1;
      end
      crc_last = crc_mb;
      fec_last = fec_mb;
      nmb++;
    end
  end

  initial begin
    seed = 32'h0a21;
    {MODE_64B66B, SCRAMBLE_EN, DATA_PHASE, SYSREF, IN_VALID} = 5'h00;
    SYNC_HEADER_MODE_SELECT = SHM_CRC12;
    IN_DATA = 64'h0;
    prev = 8'h00;
    rx_prev = 8'h00;
    RST_N = 1'b0;
    repeat (6) @(negedge CLOCK);
    RST_N = 1'b1;
    sysref();
    for (int r = 0; r < 3; r++) begin
      @(negedge CLOCK);
      DATA_PHASE = r > 0;
      SCRAMBLE_EN = r == 2;
      // Back to back words outrun the drain and fill the buffer
      for (int n = 0; n < 8; n++) word8();
      @(negedge CLOCK);
      IN_VALID = 1'b0;
      k = 0;
      while (cq.size() != 0) begin
        if (++k > 500) bail();
        @(negedge CLOCK);
      end
      repeat (4) @(negedge CLOCK);
    end
    cmp_val(saw_full, 1);
    @(negedge CLOCK);
    MODE_64B66B = 1'b1;
    chk64 = 1;
    for (int m = 0; m < 2; m++) begin
      @(negedge CLOCK);
      SYNC_HEADER_MODE_SELECT = m ? SHM_FEC : SHM_CRC12;
      SCRAMBLE_EN = (m == 1);
      sysref();
      {synced, have_prev} = 2'h0;
      nmb = 0;
      for (int n = 0; n < 10; n++) begin
        w = {$random(seed), $random(seed)} | 64'h1;
        wq.push_back(w);
        push(w);
        @(negedge CLOCK);
        IN_VALID = 1'b0;
        repeat ($random(seed) & 7) @(negedge CLOCK);
      end
      k = 0;
      while (nmb < 6) begin
        if (++k > 1500) bail();
        @(negedge CLOCK);
      end
    end
    cmp_val(wq.size(), 0);
    cmp_val(bad_sh, 0);
    cmp_val(oq.size(), 0);
    cmp_val(rx_mis, 0);
    tally_and_finish();
  end
endmodule // tb_jla_link_align
